// *** tsq_trace_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsq_trace_seq #(
  parameter int SLOTS     = 2,
  parameter int GRAD_MAX  = 4,
  parameter int OVF_DEPTH = GRAD_MAX - SLOTS,
  parameter int AD_W      = 16
) (
  // clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 rst_n,
  // trace control
  input  wire logic                                 trace_enable,
  // graduation from the reorder buffer
  input  wire logic                                 grad_valid,
  input  wire logic [$clog2(GRAD_MAX+1)-1:0]        grad_count,
  input  wire tsq_pkg::tsq_instr_s [GRAD_MAX-1:0]   grad_instr,
  output logic                                      grad_ready,
  // late data
  input  wire logic                                 late_valid,
  input  wire logic [tsq_pkg::WORD_W-1:0]           late_data,
  input  wire logic [tsq_pkg::TAG_W-1:0]            late_tag,
  output logic                                      late_done,
  // trace slots
  output logic                                      trace_valid,
  output logic [SLOTS-1:0][2:0]                     graduation_status,
  output logic [SLOTS-1:0][2:0]                     transfer_kind,
  output logic [SLOTS-1:0][AD_W-1:0]                trace_ad,
  output logic [SLOTS-1:0]                          transfer_last_flag,
  output logic                                      sync_mode_record,
  output logic [tsq_pkg::TAG_W-1:0]                 data_order_tag
);
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CYC   = tsq_pkg::WORD_W / AD_W;
  localparam int TOT   = OVF_DEPTH + GRAD_MAX;
  localparam int OCNTW = $clog2(OVF_DEPTH + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tsq_pkg::tsq_instr_s                               ovf_r [OVF_DEPTH];
  tsq_pkg::tsq_instr_s                               ovf_nxt [OVF_DEPTH];
  logic [OCNTW-1:0]                                  ovf_cnt_r, ovf_cnt_nxt;
  tsq_pkg::tsq_state_e                               state_r, state_nxt;
  logic [tsq_pkg::WIN_W-1:0]                         win_left_r, win_left_nxt;
  logic [SLOTS-1:0][2:0]                             status_r, status_nxt;
  logic                                              valid_r, valid_nxt;
  logic                                              sync_pend_r, sync_pend_nxt;
  logic                                              sync_rec_r, sync_rec_nxt;
  logic                                              ready_r, ready_nxt;
  logic                                              done_r, done_nxt;
  logic [tsq_pkg::TAG_W-1:0]                         tag_r, tag_nxt;

  // ----------------------------------------------------------------
  // working values
  // ----------------------------------------------------------------
  tsq_pkg::tsq_instr_s                               merged [TOT];
  logic [SLOTS-1:0][tsq_pkg::XFER_MAX-1:0][2:0]      cfg_kind;
  logic [SLOTS-1:0][tsq_pkg::XFER_MAX-1:0][tsq_pkg::WORD_W-1:0] cfg_word;
  logic [SLOTS-1:0][tsq_pkg::NX_W-1:0]               cfg_n;
  logic                                              accepted;
  logic                                              can_rep;
  logic                                              can_rep_next;
  logic                                              late_take;
  logic                                              load_all;
  int                                                total;
  int                                                nrep;
  int                                                win;
  int                                                k;

  // ----------------------------------------------------------------
  // next state of the sequencer
  // ----------------------------------------------------------------
  always_comb begin
    accepted = grad_valid && ready_r;
    total = int'(ovf_cnt_r) + (accepted ? int'(grad_count) : 0);
    // buffered surplus first, then this cycle's graduates
    for (int i = 0; i < TOT; i++) begin
      merged[i] = '0;
      if (i < int'(ovf_cnt_r)) begin
        merged[i] = ovf_r[i];
      end else if (i - int'(ovf_cnt_r) < GRAD_MAX) begin
        merged[i] = grad_instr[i - int'(ovf_cnt_r)];
      end
    end
    // report only while trace_valid is up and when the window can take a group
    can_rep = valid_r && (state_r == tsq_pkg::TSQ_IDLE || win_left_r == 1);
    nrep = 0;
    if (can_rep) begin
      nrep = (total < SLOTS) ? total : SLOTS;
    end
    late_take = late_valid && can_rep && (nrep == 0) && !done_r;
    load_all = (nrep > 0) || late_take;
    win = 0;
    k = 0;
    // program order onto ascending slots, empty slots show none
    for (int s = 0; s < SLOTS; s++) begin
      status_nxt[s] = tsq_pkg::ST_NONE;
      cfg_kind[s] = '0;
      cfg_word[s] = '0;
      k = 0;
      if (s < nrep) begin
        status_nxt[s] = merged[s].status;
        // first instruction after a start carries the full pc
        if (s == 0 && sync_pend_r) begin
          cfg_kind[s][k] = tsq_pkg::KIND_PC;
          cfg_word[s][k] = merged[s].pc;
          k = k + 1;
        end
        // address and data go out on the reporting slot
        if (merged[s].has_addr) begin
          cfg_kind[s][k] = (merged[s].status == tsq_pkg::ST_LOAD ||
                            merged[s].status == tsq_pkg::ST_BR_LOAD) ?
                           tsq_pkg::KIND_LD_ADDR : tsq_pkg::KIND_ST_ADDR;
          cfg_word[s][k] = merged[s].addr;
          k = k + 1;
        end
        if (merged[s].has_data) begin
          cfg_kind[s][k] = tsq_pkg::KIND_DATA;
          cfg_word[s][k] = merged[s].data;
          k = k + 1;
        end
      end else if (s == 0 && late_take) begin
        // late data rides slot 0, only in a cycle with no report
        cfg_kind[s][0] = tsq_pkg::KIND_LATE_DATA;
        cfg_word[s][0] = late_data;
        k = 1;
      end
      cfg_n[s] = tsq_pkg::NX_W'(k);
      // window is as long as the longest transfer list
      if (k * CYC > win) begin
        win = k * CYC;
      end
    end
    // window bookkeeping
    state_nxt = state_r;
    win_left_nxt = win_left_r;
    if (load_all && win > 0) begin
      state_nxt = tsq_pkg::TSQ_XFER;
      win_left_nxt = tsq_pkg::WIN_W'(win);
    end else if (state_r == tsq_pkg::TSQ_XFER) begin
      win_left_nxt = tsq_pkg::WIN_W'(win_left_r - 1'b1);
      if (win_left_r == 1) begin
        state_nxt = tsq_pkg::TSQ_IDLE;
      end
    end
    // keep what did not fit, discard all while tracing is off
    for (int j = 0; j < OVF_DEPTH; j++) begin
      ovf_nxt[j] = (nrep + j < TOT) ? merged[nrep + j] : '0;
    end
    ovf_cnt_nxt = valid_r ? OCNTW'(total - nrep) : '0;
    // while tracing, stall the reorder buffer unless the worst burst fits next cycle; always ready while off
    can_rep_next = (state_nxt == tsq_pkg::TSQ_IDLE) || (win_left_nxt == 1);
    if (!trace_enable) begin
      ready_nxt = 1'b1;
    end else begin
      ready_nxt = can_rep_next &&
                  (int'(ovf_cnt_nxt) + GRAD_MAX <= OVF_DEPTH + SLOTS);
    end
    // one qualifier for every slot output
    valid_nxt = trace_enable;
    if (trace_enable && !valid_r) begin
      sync_pend_nxt = 1'b1;
    end else if (nrep > 0) begin
      sync_pend_nxt = 1'b0;
    end else begin
      sync_pend_nxt = sync_pend_r;
    end
    sync_rec_nxt = sync_pend_r && (nrep > 0);
    done_nxt = late_take;
    tag_nxt = late_take ? late_tag : tag_r;
  end

  // register the sequencer state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int j = 0; j < OVF_DEPTH; j++) begin
        ovf_r[j] <= '0;
      end
      ovf_cnt_r   <= '0;
      state_r     <= tsq_pkg::TSQ_IDLE;
      win_left_r  <= '0;
      status_r    <= '0;
      valid_r     <= 1'b0;
      sync_pend_r <= 1'b0;
      sync_rec_r  <= 1'b0;
      ready_r     <= 1'b0;
      done_r      <= 1'b0;
      tag_r       <= '0;
    end else begin
      for (int j = 0; j < OVF_DEPTH; j++) begin
        ovf_r[j] <= ovf_nxt[j];
      end
      ovf_cnt_r   <= ovf_cnt_nxt;
      state_r     <= state_nxt;
      win_left_r  <= win_left_nxt;
      status_r    <= status_nxt;
      valid_r     <= valid_nxt;
      sync_pend_r <= sync_pend_nxt;
      sync_rec_r  <= sync_rec_nxt;
      ready_r     <= ready_nxt;
      done_r      <= done_nxt;
      tag_r       <= tag_nxt;
    end
  end

  // ----------------------------------------------------------------
  // per-slot lanes
  // ----------------------------------------------------------------
  tsq_lane_if #(.AD_W(AD_W)) lane_bus [SLOTS] ();

  // one lane per slot, all loaded together
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_lane
      assign lane_bus[g].load    = load_all;
      assign lane_bus[g].win_len = tsq_pkg::WIN_W'(win);
      assign lane_bus[g].n_xfer  = cfg_n[g];
      assign lane_bus[g].kind    = cfg_kind[g];
      assign lane_bus[g].word    = cfg_word[g];
      // replicated slot outputs, all slots end their transfers in the same cycle
      assign transfer_kind[g]      = lane_bus[g].kind_out;
      assign trace_ad[g]           = lane_bus[g].ad_out;
      assign transfer_last_flag[g] = lane_bus[g].last_out;

      tsq_slot_lane #(
        .AD_W (AD_W)
      ) u_lane (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (lane_bus[g])
      );
    end
  endgenerate

  // remaining outputs straight from flops
  assign graduation_status = status_r;
  assign trace_valid       = valid_r;
  assign grad_ready        = ready_r;
  assign late_done         = done_r;
  assign sync_mode_record  = sync_rec_r;
  assign data_order_tag    = tag_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [SLOTS-1:0] end_ok;

  // each slot at a window's last cycle is idle or ending
  always_comb begin
    for (int s = 0; s < SLOTS; s++) begin
      end_ok[s] = (transfer_kind[s] == tsq_pkg::KIND_NONE) || transfer_last_flag[s];
    end
  end

  a_none_when_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (nrep == 0) |=> (graduation_status == '0))
    else $error("slot status not none in a cycle with no report");

  a_ovf_goes_first: assert property (@(posedge mclk) disable iff (!rst_n)
    (ovf_cnt_r != '0 && can_rep) |=> (graduation_status[0] == $past(ovf_r[0].status)))
    else $error("buffered instruction not reported first");

  a_ovf_in_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    int'(ovf_cnt_r) <= OVF_DEPTH)
    else $error("overflow buffer count above its depth");

  a_sync_on_slot0: assert property (@(posedge mclk) disable iff (!rst_n)
    (sync_pend_r && nrep > 0) |-> (cfg_kind[0][0] == tsq_pkg::KIND_PC) ##1
    (sync_mode_record && graduation_status[0] != tsq_pkg::ST_NONE))
    else $error("sync record without pc on slot zero");

  a_ends_aligned: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == tsq_pkg::TSQ_XFER && win_left_r == 1) |-> (&end_ok))
    else $error("slot transfers do not end together");

  generate
    if (SLOTS > 1) begin : g_chk
      a_slot_packing: assert property (@(posedge mclk) disable iff (!rst_n)
        (graduation_status[1] != tsq_pkg::ST_NONE) |-> (graduation_status[0] != tsq_pkg::ST_NONE))
        else $error("higher slot used while slot zero empty");
    end
  endgenerate

endmodule
`default_nettype wire

// *** tsq_pkg.sv ***
// ----------------------------------------------------------------
// shared constants and types of the trace sequencer
// ----------------------------------------------------------------
package tsq_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int WORD_W   = 32;  // width of pc, address and data words
  localparam int TAG_W    = 4;   // width of the late data order tag
  localparam int XFER_MAX = 3;   // pc, address and data per instruction
  localparam int NX_W     = 2;   // width of a transfer count
  localparam int WIN_W    = 5;   // width of a transfer window length

  // ----------------------------------------------------------------
  // graduation status codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ST_NONE      = 3'h0;
  localparam logic [2:0] ST_PLAIN     = 3'h1;
  localparam logic [2:0] ST_LOAD      = 3'h2;
  localparam logic [2:0] ST_STORE     = 3'h3;
  localparam logic [2:0] ST_PCSYNC    = 3'h4;
  localparam logic [2:0] ST_BR        = 3'h5;
  localparam logic [2:0] ST_BR_LOAD   = 3'h6;
  localparam logic [2:0] ST_BR_STORE  = 3'h7;

  // ----------------------------------------------------------------
  // transfer kinds on the per-slot address/data bus
  // ----------------------------------------------------------------
  localparam logic [2:0] KIND_NONE      = 3'h0;
  localparam logic [2:0] KIND_PC        = 3'h1;
  localparam logic [2:0] KIND_LD_ADDR   = 3'h2;
  localparam logic [2:0] KIND_ST_ADDR   = 3'h3;
  localparam logic [2:0] KIND_DATA      = 3'h4;
  localparam logic [2:0] KIND_LATE_DATA = 3'h5;

  // ----------------------------------------------------------------
  // one graduating instruction, as handed over by the reorder buffer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        status;
    logic [WORD_W-1:0] pc;
    logic              has_addr;
    logic [WORD_W-1:0] addr;
    logic              has_data;
    logic [WORD_W-1:0] data;
  } tsq_instr_s;

  // ----------------------------------------------------------------
  // transfer window state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSQ_IDLE = 2'b01,
    TSQ_XFER = 2'b10
  } tsq_state_e;

endpackage

// *** tsq_lane_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// carrier between the sequencer and one slot lane
// ----------------------------------------------------------------
interface tsq_lane_if #(
  parameter int AD_W = 16
);
  logic                                                  load;
  logic [tsq_pkg::WIN_W-1:0]                             win_len;
  logic [tsq_pkg::NX_W-1:0]                              n_xfer;
  logic [tsq_pkg::XFER_MAX-1:0][2:0]                     kind;
  logic [tsq_pkg::XFER_MAX-1:0][tsq_pkg::WORD_W-1:0]     word;
  logic [2:0]                                            kind_out;
  logic [AD_W-1:0]                                       ad_out;
  logic                                                  last_out;

  modport eng  (output load, win_len, n_xfer, kind, word,
                input  kind_out, ad_out, last_out);
  modport lane (input  load, win_len, n_xfer, kind, word,
                output kind_out, ad_out, last_out);
endinterface
`default_nettype wire

// *** tsq_slot_lane.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// one trace slot: plays its transfers so they end with the window
// ----------------------------------------------------------------
module tsq_slot_lane #(
  parameter int AD_W = 16
) (
  // clock and reset
  input wire logic     mclk,
  input wire logic     rst_n,
  // sequencer side
  tsq_lane_if.lane     bus
);
  localparam int CYC = tsq_pkg::WORD_W / AD_W;

  logic [tsq_pkg::XFER_MAX-1:0][2:0]                 kind_r, kind_nxt;
  logic [tsq_pkg::XFER_MAX-1:0][tsq_pkg::WORD_W-1:0] word_r, word_nxt;
  logic [tsq_pkg::NX_W-1:0]                          n_r, n_nxt;
  logic [tsq_pkg::WIN_W-1:0]                         win_r, win_nxt;
  logic [tsq_pkg::WIN_W-1:0]                         pos_r, pos_nxt;
  logic                                              act_r, act_nxt;
  logic [2:0]                                        okind_r, okind_nxt;
  logic [AD_W-1:0]                                   oad_r, oad_nxt;
  logic                                              olast_r, olast_nxt;
  int                                                start, idx, sub;

  // pick config, then the word slice for this cycle of the window
  always_comb begin
    start = 0;
    idx = 0;
    sub = 0;
    if (bus.load) begin
      kind_nxt = bus.kind;
      word_nxt = bus.word;
      n_nxt    = bus.n_xfer;
      win_nxt  = bus.win_len;
      pos_nxt  = '0;
      act_nxt  = (bus.win_len != '0);
    end else begin
      kind_nxt = kind_r;
      word_nxt = word_r;
      n_nxt    = n_r;
      win_nxt  = win_r;
      pos_nxt  = tsq_pkg::WIN_W'(pos_r + 1'b1);
      act_nxt  = act_r && (int'(pos_r) + 1 < int'(win_r));
    end
    okind_nxt = tsq_pkg::KIND_NONE;
    oad_nxt   = '0;
    olast_nxt = 1'b0;
    // short transfer lists are padded at the front so all end together
    start = int'(win_nxt) - int'(n_nxt) * CYC;
    if (act_nxt && int'(pos_nxt) >= start) begin
      idx = (int'(pos_nxt) - start) / CYC;
      sub = (int'(pos_nxt) - start) % CYC;
      okind_nxt = kind_nxt[idx];
      oad_nxt   = word_nxt[idx][sub*AD_W +: AD_W];               // low part first
      olast_nxt = (sub == CYC - 1);
    end
  end

  // register lane state and outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      kind_r  <= '0;
      word_r  <= '0;
      n_r     <= '0;
      win_r   <= '0;
      pos_r   <= '0;
      act_r   <= 1'b0;
      okind_r <= tsq_pkg::KIND_NONE;
      oad_r   <= '0;
      olast_r <= 1'b0;
    end else begin
      kind_r  <= kind_nxt;
      word_r  <= word_nxt;
      n_r     <= n_nxt;
      win_r   <= win_nxt;
      pos_r   <= pos_nxt;
      act_r   <= act_nxt;
      okind_r <= okind_nxt;
      oad_r   <= oad_nxt;
      olast_r <= olast_nxt;
    end
  end

  // outputs straight from the flops
  assign bus.kind_out = okind_r;
  assign bus.ad_out   = oad_r;
  assign bus.last_out = olast_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_last_cont_kind: assert property (@(posedge mclk) disable iff (!rst_n)
    (okind_r != tsq_pkg::KIND_NONE && !olast_r) |=> (okind_r == $past(okind_r)))
    else $error("transfer kind changed before its last cycle");

  a_pad_short_list: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus.load && bus.n_xfer != '0 && int'(bus.n_xfer) * CYC < int'(bus.win_len))
    |=> (okind_r == tsq_pkg::KIND_NONE))
    else $error("short transfer list not padded at window start");

endmodule
`default_nettype wire

// *** tsq_trace_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// trace receiver: counts reports in slot order
// --------------------------------------------
module tsq_trace_rx (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // slot outputs of the sequencer
  input  wire logic            trace_valid,
  input  wire logic [1:0][2:0] graduation_status,
  // instructions collected so far
  output logic      [15:0]     n_seen
);
  // only qualified slots count, slot 0 and slot 1 added in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      n_seen <= 16'h0;
    end else if (trace_valid) begin
      n_seen <= n_seen + 16'(graduation_status[0] != 3'h0)
                + 16'(graduation_status[1] != 3'h0);
    end
  end
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                      mclk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      trace_enable = 1'b0;
  logic                      grad_valid = 1'b0;
  logic [2:0]                grad_count = 3'h0;
  tsq_pkg::tsq_instr_s [3:0] grad_instr = '0;
  logic                      late_valid = 1'b0;
  logic [31:0]               late_data = 32'h0;
  logic [3:0]                late_tag = 4'h0;
  logic                      grad_ready, late_done, trace_valid, sync_mode_record;
  logic [3:0]                data_order_tag;
  logic [1:0][2:0]           graduation_status, transfer_kind;
  logic [1:0][15:0]          trace_ad;
  logic [1:0]                transfer_last_flag;
  logic [15:0]               n_seen;
  logic [3:0]                exp_q[$];
  logic                      need_sync = 1'b0;
  int                        n_exp = 0;
  int                        err_total = 0;
  int                        comparisons = 0;

  // clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  tsq_trace_seq #(.SLOTS(2), .GRAD_MAX(4), .AD_W(16)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .trace_enable(trace_enable),
    .grad_valid(grad_valid), .grad_count(grad_count), .grad_instr(grad_instr),
    .grad_ready(grad_ready), .late_valid(late_valid), .late_data(late_data),
    .late_tag(late_tag), .late_done(late_done), .trace_valid(trace_valid),
    .graduation_status(graduation_status), .transfer_kind(transfer_kind),
    .trace_ad(trace_ad), .transfer_last_flag(transfer_last_flag),
    .sync_mode_record(sync_mode_record), .data_order_tag(data_order_tag));

  tsq_trace_rx rx_u (.mclk(mclk), .rst_n(rst_n), .trace_valid(trace_valid),
    .graduation_status(graduation_status), .n_seen(n_seen));

  task automatic cmp(input string nm, input logic [3:0] e, input logic [3:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmp_w(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one graduation group of n instructions, entered at a falling edge;
  // valid stays up so a following group can go back to back
  task automatic send(input int n);
    int i;
    i = 0;
    while (grad_ready !== 1'b1 && i < 60) begin
      grad_valid = 1'b0;
      @(negedge mclk);
      i++;
    end
    if (i == 60) begin
      err_total++;
      close_out();
    end else begin
      grad_valid = 1'b1;
      grad_count = 3'(n);
      for (int k = 0; k < 4; k++) begin
        grad_instr[k] = {3'($urandom_range(1, 7)), $urandom, 1'($urandom), $urandom,
                         1'($urandom), $urandom};
        if (k < n && trace_valid === 1'b1) begin
          exp_q.push_back({need_sync, grad_instr[k].status});
          need_sync = 1'b0;
          n_exp++;
        end
      end
      @(negedge mclk);
    end
  endtask

  // pairs each reported slot with the oldest noted instruction, off the launch edge
  always @(negedge mclk) begin
    if (rst_n && trace_valid === 1'b1) begin
      if (graduation_status[1] !== 3'h0)
        cmp("slot0_used", 4'h1, {3'h0, graduation_status[0] != 3'h0});
      for (int k = 0; k < 2; k++) begin
        if (graduation_status[k] !== 3'h0 && exp_q.size() == 0)
          cmp("status", 4'h0, {1'b0, graduation_status[k]});
        else if (graduation_status[k] !== 3'h0)
          cmp("status", exp_q.pop_front(),
              {sync_mode_record & (k == 0), graduation_status[k]});
        if (transfer_last_flag !== 2'b00)
          cmp("last", {3'h0, transfer_kind[k] != tsq_pkg::KIND_NONE},
              {3'h0, transfer_last_flag[k]});
      end
    end
  end

  // reset, idle, groups, late data, trace restart
  initial begin
    int i;
    void'($urandom(32'h7ded));
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    for (int r = 0; r < 2; r++) begin
      trace_enable = 1'b1;
      need_sync = 1'b1;
      @(negedge mclk);
      send(1);
      for (int g = 0; g < 14; g++) send($urandom_range(1, 4));
      grad_valid = 1'b0;
      i = 0;
      while ((exp_q.size() != 0 || grad_ready !== 1'b1) && i < 200) begin
        @(negedge mclk);
        i++;
      end
      if (i == 200) err_total++;
      late_valid = 1'b1;
      late_tag = 4'($urandom);
      late_data = $urandom;
      i = 0;
      while (late_done !== 1'b1 && i < 50) begin
        @(negedge mclk);
        i++;
      end
      if (i == 50) err_total++;
      cmp("late_kind", {1'b0, tsq_pkg::KIND_LATE_DATA}, {1'b0, transfer_kind[0]});
      cmp("order_tag", late_tag, data_order_tag);
      cmp_w("late_lo", late_data[15:0], trace_ad[0]);
      late_valid = 1'b0;
      @(negedge mclk);
      cmp_w("late_hi", late_data[31:16], trace_ad[0]);
      cmp("late_last", 4'h1, {3'h0, transfer_last_flag[0]});
      repeat (3) @(negedge mclk);
      trace_enable = 1'b0;
      repeat (2) @(negedge mclk);
      send(2);
      grad_valid = 1'b0;
      repeat (20) @(negedge mclk);
    end
    cmp("left", 4'h0, 4'(exp_q.size()));
    cmp_w("rx_count", 16'(n_exp), n_seen);
    close_out();
  end
endmodule
`default_nettype wire
